/* design/sfcr_pkg.sv */
// sfcr_pkg: offsets, field positions, reset values and serial frame sizes of the
// synthesizer frequency-control register bank.
// assumes byte-wide registers behind a 15-bit serial register address.
package sfcr_pkg;

    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int FRAME_BITS = 24;
    localparam int HDR_BITS   = 16;

    localparam logic [ADDR_W-1:0] ADDR_MAKER_LOW  = 15'h000c;
    localparam logic [ADDR_W-1:0] ADDR_MAKER_HIGH = 15'h000d;
    localparam logic [ADDR_W-1:0] ADDR_INT_LOW    = 15'h0010;
    localparam logic [ADDR_W-1:0] ADDR_INT_HIGH   = 15'h0011;
    localparam logic [ADDR_W-1:0] ADDR_FRAC1_B0   = 15'h0012;
    localparam logic [ADDR_W-1:0] ADDR_FRAC1_B1   = 15'h0013;
    localparam logic [ADDR_W-1:0] ADDR_FRAC1_B2   = 15'h0014;
    localparam logic [ADDR_W-1:0] ADDR_CORE_MODE  = 15'h0015;
    localparam logic [ADDR_W-1:0] ADDR_BAND_HIGH  = 15'h0016;
    localparam logic [ADDR_W-1:0] ADDR_FRAC2_B0   = 15'h0017;
    localparam logic [ADDR_W-1:0] ADDR_FRAC2_B1   = 15'h0018;
    localparam logic [ADDR_W-1:0] ADDR_FRAC2_B2   = 15'h0019;
    localparam logic [ADDR_W-1:0] ADDR_MOD_B0     = 15'h001a;
    localparam logic [ADDR_W-1:0] ADDR_MOD_B1     = 15'h001b;
    localparam logic [ADDR_W-1:0] ADDR_MOD_B2     = 15'h001c;
    localparam logic [ADDR_W-1:0] ADDR_LEAK_LOW   = 15'h001d;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_LEAK  = 15'h001e;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_PUMP  = 15'h001f;
    localparam logic [ADDR_W-1:0] ADDR_CAL_REF    = 15'h0020;
    localparam int                NUM_REGS        = 17;

    localparam logic [DATA_W-1:0] RST_INT_LOW = 8'h80;
    localparam logic [DATA_W-1:0] RST_CAL_REF = 8'h01;
    localparam logic [DATA_W-1:0] RST_ZERO    = 8'h00;

    // field positions inside their byte
    localparam int OUT_DIV_LSB   = 5;
    localparam int INVERT_BIT    = 4;
    localparam int INT_HIGH_MSB  = 3;
    localparam int BAND0_BIT     = 7;
    localparam int CORE_BIT      = 6;
    localparam int INT_MODE_BIT  = 2;
    localparam int POLARITY_BIT  = 1;
    localparam int FRAC_MSB_BIT  = 0;
    localparam int RESYNC_BIT    = 7;
    localparam int REF_RST_BIT   = 6;
    localparam int TIMED_BIT     = 5;
    localparam int LEAK_HIGH_MSB = 4;
    localparam int SOFTWARE_SYNC_REQUEST_BIT   = 7;
    localparam int LEAK_POL_BIT  = 5;
    localparam int LEAK_EN_BIT   = 4;
    localparam int PUMP_MSB      = 3;
    localparam int CAL_EN_BIT    = 7;
    localparam int DOUBLER_BIT   = 6;
    localparam int REF_DIV_MSB   = 5;

    typedef enum logic {SFCR_CAL_IDLE, SFCR_CAL_RUN} sfcr_cal_t;

    function automatic logic sfcr_in_bank(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_INT_LOW) && (a <= ADDR_CAL_REF);
    endfunction : sfcr_in_bank

    function automatic logic [4:0] sfcr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - ADDR_INT_LOW;
        return d[4:0];
    endfunction : sfcr_index

    function automatic logic [DATA_W-1:0] sfcr_reset_value(input int i);
        if (i == 0) begin
            return RST_INT_LOW;
        end else if (i == NUM_REGS - 1) begin
            return RST_CAL_REF;
        end
        return RST_ZERO;
    endfunction : sfcr_reset_value

endpackage : sfcr_pkg

/* design/sfcr_serial.sv */
// sfcr_serial: four-wire serial register port, one byte per frame.
// assumes the serial clock and chip select are sampled on I_CLOCK and that each
// serial clock half period lasts at least two I_CLOCK cycles.
`timescale 1ns/100ps
module sfcr_serial
    import sfcr_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic              i_sclk,
    input  wire logic              i_cs_n,
    input  wire logic              i_sdi,
    input  wire logic [DATA_W-1:0] i_rdata,
    output logic                   o_sdo,
    output logic                   o_sdo_oe,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [DATA_W-1:0]      o_wdata,
    output logic                   o_wr
);
    logic              sclk_q;
    logic [4:0]        count;
    logic [FRAME_BITS-2:0] shift_in;
    logic [DATA_W-1:0] shift_out;
    logic              is_read;
    logic              load_pend;

    wire rise      = i_sclk && !sclk_q && !i_cs_n;
    wire fall      = !i_sclk && sclk_q && !i_cs_n;
    wire hdr_last  = rise && (count == 5'(HDR_BITS - 1));
    wire data_last = rise && (count == 5'(FRAME_BITS - 1));

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            count  <= 5'h00;
        end else begin
            sclk_q <= i_sclk;
            // bits after a full frame are ignored until chip select rises
            if (i_cs_n) begin
                count <= 5'h00;
            end else if (rise && count != 5'(FRAME_BITS)) begin
                count <= count + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shift_in  <= '0;
            o_addr    <= '0;
            is_read   <= 1'b0;
            load_pend <= 1'b0;
        end else begin
            if (rise) begin
                shift_in <= {shift_in[FRAME_BITS-3:0], i_sdi};
            end
            load_pend <= hdr_last;
            if (hdr_last) begin
                is_read <= shift_in[HDR_BITS-2];
                o_addr  <= {shift_in[ADDR_W-2:0], i_sdi};
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wr    <= 1'b0;
            o_wdata <= '0;
        end else begin
            o_wr <= data_last && !is_read;
            if (data_last) begin
                o_wdata <= {shift_in[DATA_W-2:0], i_sdi};
            end
        end
    end

    // read data leaves on falling edges, first bit before the first data rise
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shift_out <= '0;
        end else if (load_pend) begin
            shift_out <= i_rdata;
        end else if (fall && count > 5'(HDR_BITS)) begin
            shift_out <= {shift_out[DATA_W-2:0], 1'b0};
        end
    end

    assign o_sdo    = shift_out[DATA_W-1];
    assign o_sdo_oe = !i_cs_n && is_read && (count >= 5'(HDR_BITS)) && !load_pend;

endmodule : sfcr_serial

/* design/sfcr_regs.sv */
// sfcr_regs: frequency-control register bank of the synthesizer, reached over
// the four-wire serial register port; drives the loop controls as plain levels.
// assumes sync pin, reference tick and calibration done are synchronous to I_CLOCK.
// Operation
// - writing the low integer byte starts calibration when calibration is enabled
// - integer word is 12 bits: low byte plus low nibble of next; low resets 0x80
// - primary fraction is 25 bits: three bytes plus bit 0 of mode register
// - secondary fraction is 24 bits over three bytes, low byte first, resets zero
// - fraction modulus is 24 bits over three bytes, low byte first, resets zero
// - one inversion bit inverts both outputs together
// - with core override, manual bit picks core: 0 highest, 1 lowest frequency
// - with band override, a 9-bit manual band is used; bit 0 sits separately
// - a single detector polarity bit sets pump drive sense, reset 0
// - with reference reset enabled, software or pin sync resets reference divider
// - timed sync retimes the reset to the reference clock, else immediate
// - phase resync enable bit, reset 0, activates resync behaviour
// - leak current only when enabled; polarity bit; 13-bit magnitude split 8 plus 5
// - calibration enable resets to 0; calibration starts only when it is 1, and a run keeps going if it is cleared
// - reference divider is 6 bits, resets to 1; separate doubler enable bit
// - read-only 16-bit maker code over two bytes, upper at 0x00d; writes ignored
`timescale 1ns/100ps
module sfcr_regs
    import sfcr_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a3c,  // value is arbitrary
    parameter int          BANK_REGS  = NUM_REGS
)
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST,
    input  wire logic        I_SCLK,
    input  wire logic        I_CS_N,
    input  wire logic        I_SDI,
    input  wire logic        I_SYNC,
    input  wire logic        I_REF_TICK,
    input  wire logic        I_CAL_DONE,
    input  wire logic        I_CORE_OVERRIDE,
    input  wire logic        I_BAND_OVERRIDE,
    output logic             O_SDO,
    output logic             O_SDO_OE,
    output logic [11:0]      O_INT_WORD,
    output logic [24:0]      O_PRIMARY_FRACTION,
    output logic [23:0]      O_SECONDARY_FRACTION,
    output logic [23:0]      O_FRACTION_MODULUS,
    output logic [2:0]       O_OUTPUT_DIVIDE_SELECT,
    output logic             O_RF1_INVERT,
    output logic             O_RF2_INVERT,
    output logic             O_INTEGER_MODE,
    output logic             O_DETECTOR_POLARITY,
    output logic             O_CORE_FORCE,
    output logic             O_CORE_SELECT,
    output logic             O_BAND_FORCE,
    output logic [8:0]       O_BAND_VALUE,
    output logic             O_LEAK_ENABLE,
    output logic             O_LEAK_SOURCE,
    output logic [12:0]      O_LEAK_MAGNITUDE,
    output logic [3:0]       O_PUMP_CURRENT_CODE,
    output logic             O_PHASE_RESYNC_EN,
    output logic             O_REF_RESET,
    output logic [5:0]       O_REFERENCE_DIVIDER,
    output logic             O_REFERENCE_DOUBLER_EN,
    output logic             O_CAL_START,
    output logic             O_CAL_BUSY,
    output logic [11:0]      O_CAL_WORD
);
    // the address decode is fixed to the register map, so no other bank size can work
    if (BANK_REGS != NUM_REGS) begin : g_bank_size
        $error("bank size must match the register map");
    end

    logic [DATA_W-1:0] bank [BANK_REGS];
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic [DATA_W-1:0] rdata;
    sfcr_cal_t         cal_state;
    sfcr_cal_t         next_cal_state;

    sfcr_serial u_serial (
        .i_clock  (I_CLOCK),
        .i_rst    (I_RST),
        .i_sclk   (I_SCLK),
        .i_cs_n   (I_CS_N),
        .i_sdi    (I_SDI),
        .i_rdata  (rdata),
        .o_sdo    (O_SDO),
        .o_sdo_oe (O_SDO_OE),
        .o_addr   (addr),
        .o_wdata  (wdata),
        .o_wr     (wr)
    );

    wire       bank_hit = sfcr_in_bank(addr);
    wire [4:0] wr_index = sfcr_index(addr);
    wire       bank_wr  = wr && bank_hit;

    wire [7:0] r_int_low  = bank[sfcr_index(ADDR_INT_LOW)];
    wire [7:0] r_int_high = bank[sfcr_index(ADDR_INT_HIGH)];
    wire [7:0] r_core     = bank[sfcr_index(ADDR_CORE_MODE)];
    wire [7:0] r_band     = bank[sfcr_index(ADDR_BAND_HIGH)];
    wire [7:0] r_sync     = bank[sfcr_index(ADDR_SYNC_LEAK)];
    wire [7:0] r_pump     = bank[sfcr_index(ADDR_SYNC_PUMP)];
    wire [7:0] r_cal      = bank[sfcr_index(ADDR_CAL_REF)];

    wire cal_enable  = r_cal[CAL_EN_BIT];
    wire ref_rst_en  = r_sync[REF_RST_BIT];
    wire timed_sync  = r_sync[TIMED_BIT];
    wire software_sync_request     = r_pump[SOFTWARE_SYNC_REQUEST_BIT];
    wire leak_en     = r_pump[LEAK_EN_BIT];
    wire cal_trigger = wr && addr == ADDR_INT_LOW && cal_enable;
    wire sync_req    = ref_rst_en && (software_sync_request || I_SYNC);
    wire ref_reset_d = timed_sync ? (sync_req && I_REF_TICK) : sync_req;

    // maker code is not in the writable bank, so writes there fall through
    assign rdata = (addr == ADDR_MAKER_LOW)  ? MAKER_CODE[7:0] :
                   (addr == ADDR_MAKER_HIGH) ? MAKER_CODE[15:8] :
                   bank_hit                  ? bank[wr_index] : 8'h00;

    // reset values per register; the integer low byte and reference setup differ
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < BANK_REGS; i++) begin
                bank[i] <= sfcr_reset_value(i);
            end
        end else if (bank_wr) begin
            bank[wr_index] <= wdata;
        end
    end

    assign O_INT_WORD = {r_int_high[INT_HIGH_MSB:0], r_int_low};
    assign O_PRIMARY_FRACTION = {r_core[FRAC_MSB_BIT], bank[sfcr_index(ADDR_FRAC1_B2)],
                                 bank[sfcr_index(ADDR_FRAC1_B1)],
                                 bank[sfcr_index(ADDR_FRAC1_B0)]};
    assign O_SECONDARY_FRACTION = {bank[sfcr_index(ADDR_FRAC2_B2)],
                                   bank[sfcr_index(ADDR_FRAC2_B1)],
                                   bank[sfcr_index(ADDR_FRAC2_B0)]};
    assign O_FRACTION_MODULUS = {bank[sfcr_index(ADDR_MOD_B2)],
                                 bank[sfcr_index(ADDR_MOD_B1)],
                                 bank[sfcr_index(ADDR_MOD_B0)]};
    assign O_OUTPUT_DIVIDE_SELECT = r_int_high[OUT_DIV_LSB+2:OUT_DIV_LSB];
    assign O_RF1_INVERT = r_int_high[INVERT_BIT];
    assign O_RF2_INVERT = r_int_high[INVERT_BIT];
    assign O_INTEGER_MODE = r_core[INT_MODE_BIT];
    assign O_DETECTOR_POLARITY = r_core[POLARITY_BIT];
    assign O_PHASE_RESYNC_EN = r_sync[RESYNC_BIT];
    assign O_REFERENCE_DIVIDER = r_cal[REF_DIV_MSB:0];
    assign O_REFERENCE_DOUBLER_EN = r_cal[DOUBLER_BIT];
    assign O_PUMP_CURRENT_CODE = r_pump[PUMP_MSB:0];
    assign O_CAL_BUSY = (cal_state == SFCR_CAL_RUN);

    // overrides and leak gating are registered so the analog side sees clean levels
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_CORE_FORCE     <= 1'b0;
            O_CORE_SELECT    <= 1'b0;
            O_BAND_FORCE     <= 1'b0;
            O_BAND_VALUE     <= 9'h000;
            O_LEAK_ENABLE    <= 1'b0;
            O_LEAK_SOURCE    <= 1'b0;
            O_LEAK_MAGNITUDE <= 13'h0000;
            O_REF_RESET      <= 1'b0;
        end else begin
            O_CORE_FORCE  <= I_CORE_OVERRIDE;
            O_CORE_SELECT <= I_CORE_OVERRIDE && r_core[CORE_BIT];
            O_BAND_FORCE  <= I_BAND_OVERRIDE;
            O_BAND_VALUE  <= I_BAND_OVERRIDE ?
                             {bank[sfcr_index(ADDR_BAND_HIGH)], r_core[BAND0_BIT]} :
                             9'h000;
            O_LEAK_ENABLE <= leak_en;
            O_LEAK_SOURCE <= r_pump[LEAK_POL_BIT];
            O_LEAK_MAGNITUDE <= leak_en ?
                                {r_sync[LEAK_HIGH_MSB:0], bank[sfcr_index(ADDR_LEAK_LOW)]} :
                                13'h0000;
            O_REF_RESET <= ref_reset_d;
        end
    end

    // a new trigger while running restarts calibration and wins over done
    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            SFCR_CAL_IDLE: begin
                if (cal_trigger) begin
                    next_cal_state = SFCR_CAL_RUN;
                end
            end
            SFCR_CAL_RUN: begin
                if (I_CAL_DONE && !cal_trigger) begin
                    next_cal_state = SFCR_CAL_IDLE;
                end
            end
            default: begin
                next_cal_state = SFCR_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            cal_state   <= SFCR_CAL_IDLE;
            O_CAL_START <= 1'b0;
            O_CAL_WORD  <= 12'h000;
        end else begin
            cal_state   <= next_cal_state;
            O_CAL_START <= cal_trigger;
            if (cal_trigger) begin
                // new low byte joins the nibble already held, giving a coherent word
                O_CAL_WORD <= {r_int_high[INT_HIGH_MSB:0], wdata};
            end
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    a_cal_start_write: assert property (
        (wr && addr == ADDR_INT_LOW && cal_enable) |=> O_CAL_START && O_CAL_BUSY)
        else $error("calibration did not start after integer low write");

    a_cal_needs_enable: assert property (
        O_CAL_START |-> $past(cal_enable) && $past(addr) == ADDR_INT_LOW && $past(wr))
        else $error("calibration started without enable or trigger write");

    a_cal_word_coherent: assert property (
        O_CAL_START |-> O_CAL_WORD == O_INT_WORD)
        else $error("calibration word differs from integer word");

    a_int_high_nibble: assert property (
        (wr && addr == ADDR_INT_HIGH) |=>
            O_INT_WORD[11:8] == $past(wdata[3:0]) && O_INT_WORD[7:0] == $past(r_int_low))
        else $error("integer upper nibble not updated alone");

    a_frac_top_bit: assert property (
        (wr && addr == ADDR_CORE_MODE) |=> O_PRIMARY_FRACTION[24] == $past(wdata[0]))
        else $error("primary fraction top bit not taken from mode register");

    a_secondary_order: assert property (
        (wr && addr == ADDR_FRAC2_B2) |=> O_SECONDARY_FRACTION[23:16] == $past(wdata))
        else $error("secondary fraction byte order wrong");

    a_modulus_order: assert property (
        (wr && addr == ADDR_MOD_B0) |=> O_FRACTION_MODULUS[7:0] == $past(wdata))
        else $error("modulus byte order wrong");

    a_invert_together: assert property (
        (wr && addr == ADDR_INT_HIGH) |=>
            O_RF1_INVERT == $past(wdata[4]) && O_RF2_INVERT == $past(wdata[4]))
        else $error("outputs not inverted together");

    a_core_manual: assert property (
        !I_CORE_OVERRIDE |=> !O_CORE_SELECT && !O_CORE_FORCE)
        else $error("core select forced without override");

    a_leak_gated: assert property (
        !leak_en |=> O_LEAK_MAGNITUDE == 13'h0000 && !O_LEAK_ENABLE)
        else $error("leak magnitude driven while disabled");

    a_ref_timed: assert property (
        (O_REF_RESET && $past(timed_sync)) |-> $past(I_REF_TICK) && $past(ref_rst_en))
        else $error("timed reference reset off the reference tick");

    a_ref_needs_enable: assert property (
        (!ref_rst_en && (I_SYNC || software_sync_request)) |=> !O_REF_RESET)
        else $error("reference reset without enable");

    a_maker_readonly: assert property (
        (addr == ADDR_MAKER_HIGH) |-> rdata == MAKER_CODE[15:8])
        else $error("maker code high byte changed");

    a_band_manual: assert property (
        I_BAND_OVERRIDE |=> O_BAND_FORCE &&
            O_BAND_VALUE == {$past(r_band), $past(r_core[BAND0_BIT])})
        else $error("manual band value not applied under override");

    a_ref_immediate: assert property (
        (ref_rst_en && !timed_sync && (I_SYNC || software_sync_request)) |=> O_REF_RESET)
        else $error("untimed sync did not reset the reference divider");

    // a serial frame lasts about 150 cycles, so done may come well after the start
    c_cal_run: cover property (O_CAL_START ##[1:400] I_CAL_DONE ##1 !O_CAL_BUSY);
    c_timed_reset: cover property (timed_sync && O_REF_RESET);
    c_band_force: cover property (O_BAND_FORCE && O_BAND_VALUE != 9'h000);
    c_serial_read: cover property (O_SDO_OE && O_SDO);

endmodule : sfcr_regs

/* test/sfcr_testbench.sv */
// testbench: serial-port driven checks of the frequency-control register bank.
// assumes frames of 24 serial clock rises, MSB first, one byte a frame.
`timescale 1ns/100ps
module testbench;
    import sfcr_pkg::*;
    localparam logic [15:0] MAKER = 16'h3c96;  // value is arbitrary
    localparam logic [7:0]  PAT[0:16] = '{8'h5c, 8'hb7, 8'h12, 8'h34, 8'h56, 8'hc7, 8'h9a,
        8'h21, 8'h43, 8'h65, 8'h87, 8'ha9, 8'hcb, 8'hed, 8'h9f, 8'h3a, 8'h6e};
    logic        clock, rst, sclk, cs_n, sdi, sync, ref_tick, cal_done, core_ov, band_ov;
    logic        sdo, sdo_oe, rf1_inv, rf2_inv, int_mode, det_pol, core_force, core_sel;
    logic        band_force, leak_en, leak_src, resync_en, ref_reset, dbl_en, cal_start;
    logic        cal_busy;
    logic [11:0] int_word, cal_word;
    logic [24:0] frac1;
    logic [23:0] frac2, modw;
    logic [2:0]  div_sel;
    logic [8:0]  band_val;
    logic [12:0] leak_mag;
    logic [3:0]  pump;
    logic [5:0]  ref_div;
    int          fails, samples_checked, cal_starts, hits;

    sfcr_regs #(.MAKER_CODE(MAKER)) u_dut (
        .I_CLOCK(clock), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi),
        .I_SYNC(sync), .I_REF_TICK(ref_tick), .I_CAL_DONE(cal_done),
        .I_CORE_OVERRIDE(core_ov), .I_BAND_OVERRIDE(band_ov), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
        .O_INT_WORD(int_word), .O_PRIMARY_FRACTION(frac1), .O_SECONDARY_FRACTION(frac2),
        .O_FRACTION_MODULUS(modw), .O_OUTPUT_DIVIDE_SELECT(div_sel), .O_RF1_INVERT(rf1_inv),
        .O_RF2_INVERT(rf2_inv), .O_INTEGER_MODE(int_mode), .O_DETECTOR_POLARITY(det_pol),
        .O_CORE_FORCE(core_force), .O_CORE_SELECT(core_sel), .O_BAND_FORCE(band_force),
        .O_BAND_VALUE(band_val), .O_LEAK_ENABLE(leak_en), .O_LEAK_SOURCE(leak_src),
        .O_LEAK_MAGNITUDE(leak_mag), .O_PUMP_CURRENT_CODE(pump),
        .O_PHASE_RESYNC_EN(resync_en), .O_REF_RESET(ref_reset), .O_REFERENCE_DIVIDER(ref_div),
        .O_REFERENCE_DOUBLER_EN(dbl_en), .O_CAL_START(cal_start), .O_CAL_BUSY(cal_busy),
        .O_CAL_WORD(cal_word));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        if (cal_start === 1'b1) cal_starts++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one whole frame; read data is taken in the low phase before rises 17 to 24
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                         output logic [7:0] rdat);
        logic [23:0] f;
        f = {rd, addr, wd};
        rdat = 8'h00;
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = f[i];
            repeat (3) @(negedge clock);
            if (rd && i < 8) begin
                rdat[i] = sdo;
                check(sdo_oe, 1'b1);
            end
            sclk = 1'b1;
            repeat (3) @(negedge clock);
        end
        sclk = 1'b0;
        repeat (3) @(negedge clock);
        cs_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : frame

    task automatic wr(input logic [14:0] addr, input logic [7:0] d);
        logic [7:0] dummy;
        frame(1'b0, addr, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        frame(1'b1, addr, 8'h00, got);
        check(got, exp);
    endtask : rd_chk

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #200000;
        fails++;
        give_verdict();
    end

    initial begin
        {rst, cs_n} = 2'b11;
        {sclk, sdi, sync, ref_tick, cal_done, core_ov, band_ov} = 7'h00;
        {fails, samples_checked, cal_starts, hits} = '0;
        repeat (16) @(negedge clock);
        check(int_word, 12'h080);
        check(frac1, 25'h0000000);
        check(frac2, 24'h000000);
        check(modw, 24'h000000);
        check(ref_div, 6'h01);
        check({det_pol, resync_en, cal_busy, cal_start}, 4'h0);
        rst = 1'b0;
        @(negedge clock);
        for (int a = 16; a <= 32; a++) begin
            rd_chk(a[14:0], (a == 16) ? 8'h80 : {7'h00, a == 32});
        end
        for (int a = 16; a <= 32; a++) wr(a[14:0], PAT[a-16]);
        check(int_word, {PAT[1][3:0], PAT[0]});
        check(frac1, {PAT[5][0], PAT[4], PAT[3], PAT[2]});
        check(frac2, {PAT[9], PAT[8], PAT[7]});
        check(modw, {PAT[12], PAT[11], PAT[10]});
        check({div_sel, rf1_inv, rf2_inv}, {PAT[1][7:4], PAT[1][4]});
        check({int_mode, det_pol}, PAT[5][2:1]);
        check({leak_en, leak_src, leak_mag, pump},
              {PAT[15][4], PAT[15][5], PAT[14][4:0], PAT[13], PAT[15][3:0]});
        check({resync_en, dbl_en, ref_div}, {PAT[14][7], PAT[16][6:0]});
        check(cal_starts, 32'h0);
        for (int a = 16; a <= 32; a++) rd_chk(a[14:0], PAT[a-16]);
        wr(15'h001f, PAT[15] & 8'hef);
        check({leak_en, leak_mag}, 14'h0000);
        for (int ov = 0; ov < 2; ov++) begin
            {core_ov, band_ov} = {2{ov[0]}};
            repeat (3) @(negedge clock);
            check({core_force, core_sel}, ov[0] ? {1'b1, PAT[5][6]} : 2'b00);
            check({band_force, band_val},
                  ov[0] ? {1'b1, PAT[6], PAT[5][7]} : 10'h000);
        end
        rd_chk(15'h000c, MAKER[7:0]);
        rd_chk(15'h000d, MAKER[15:8]);
        wr(15'h000d, ~MAKER[15:8]);
        rd_chk(15'h000d, MAKER[15:8]);
        rd_chk(15'h0030, 8'h00);
        // calibration must freeze the word seen at the trigger, not follow later writes
        wr(15'h0020, 8'h81);
        wr(15'h0011, 8'h0d);
        wr(15'h0010, 8'h3c);
        check(cal_starts, 32'h1);
        check({cal_busy, cal_word}, {1'b1, 12'hd3c});
        wr(15'h0011, 8'h02);
        check({cal_word, int_word}, {12'hd3c, 12'h23c});
        cal_done = 1'b1;
        @(negedge clock);
        cal_done = 1'b0;
        repeat (2) @(negedge clock);
        check(cal_busy, 1'b0);
        wr(15'h0020, 8'h01);
        wr(15'h0010, 8'h11);
        check(cal_starts, 32'h1);
        check(cal_busy, 1'b0);
        wr(15'h001e, 8'h40);
        sync = 1'b1;
        repeat (2) @(negedge clock);
        check(ref_reset, 1'b1);
        sync = 1'b0;
        repeat (2) @(negedge clock);
        check(ref_reset, 1'b0);
        wr(15'h001f, 8'h80);
        check(ref_reset, 1'b1);
        wr(15'h001e, 8'h60);
        check(ref_reset, 1'b0);
        ref_tick = 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge clock);
            ref_tick = 1'b0;
            hits += ref_reset;
        end
        check(hits, 32'h1);
        wr(15'h001e, 8'h00);
        check(ref_reset, 1'b0);
        give_verdict();
    end
endmodule : testbench
